// ### pwmg_regs.vh
// Register addresses, field positions and reset values of the PWM block.
`ifndef PWMG_REGS_VH
`define PWMG_REGS_VH
`define PWMG_ADDR_IE2        8'h84
`define PWMG_ADDR_FLG2       8'h85
`define PWMG_ADDR_IE1        8'hA9
`define PWMG_ADDR_CON        8'hA1
`define PWMG_ADDR_OE         8'hA6
`define PWMG_ADDR_CTRL0      8'hB0
`define PWMG_ADDR_PAIR_FIRST 8'hB1
`define PWMG_ADDR_PAIR_LAST  8'hC2
`define PWMG_PAIR_CH0_PRD    4'h0
`define PWMG_PAIR_CH0_DUTY   4'h1
`define PWMG_PAIR_SH_PRD     4'h2
`define PWMG_PAIR_SH_DUTY0   4'h3
`define PWMG_PAIR_COUNT      9
`define PWMG_PAIR_NONE       4'hF
`define PWMG_IE2_SHARED      6
`define PWMG_IE2_CH0         5
`define PWMG_IE1_ALL         7
`define PWMG_IE2_MASK        8'h60
`define PWMG_CON_SH_CKS_HI   7
`define PWMG_CON_SH_CKS_LO   6
`define PWMG_CON_SH_EN       5
`define PWMG_CON_CH0_CKS_HI  3
`define PWMG_CON_CH0_CKS_LO  2
`define PWMG_CON_NMSK        1
`define PWMG_CON_PMSK        0
`define PWMG_CON_MASK        8'hEF
`define PWMG_OE_NEG_B        3
`define PWMG_OE_POS_B        2
`define PWMG_OE_NEG_A        1
`define PWMG_OE_POS_A        0
`define PWMG_OE_SH_HI        7
`define PWMG_OE_SH_LO        4
`define PWMG_CTRL_CLEAR      0
`define PWMG_CTRL_MSKE       1
`define PWMG_CTRL_HALF       2
`define PWMG_CTRL_DZ_HI      7
`define PWMG_CTRL_DZ_LO      4
`define PWMG_CTRL_MASK       8'hF7
`define PWMG_CKS_RC          2'h2
`define PWMG_CKS_RC2         2'h3
`define PWMG_RST_BYTE        8'h00
`define PWMG_RST_WORD        16'h0000
`define PWMG_DT_ZERO         5'h00
`define PWMG_DT_MAX          5'h1F
`endif

// ### pwmg_top.v
// Seven-channel PWM generator with byte-wide register port.
`timescale 1ns/10ps
`default_nettype none
`include "pwmg_regs.vh"
module pwmg_top #(
    parameter W  = 16,
    parameter NS = 6
) (
    // Clock and reset.
    input  wire          clk,
    input  wire          resetn,
    // Register port.
    input  wire [7:0]    reg_addr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [7:0]    reg_rdata,
    // Asynchronous oscillator inputs.
    input  wire          internal_rc_clock,
    input  wire          internal_rc_clock_x2,
    // Channel zero outputs.
    output reg           ch0_pos_output,
    output reg           ch0_neg_output,
    // Shared channel outputs.
    output reg  [NS-1:0] shared_output,
    // Interrupt requests.
    output reg           ch0_irq,
    output reg           shared_irq
);

    function sel_tick;
        input [1:0] sel;
        input       rc;
        input       rc2;
        begin
            if (sel == `PWMG_CKS_RC2) begin
                sel_tick = rc2;
            end else if (sel == `PWMG_CKS_RC) begin
                sel_tick = rc;
            end else begin
                sel_tick = 1'b1;
            end
        end
    endfunction

    function [3:0] pair_of;
        input [7:0] a;
        reg   [7:0] off;
        begin
            off = a - `PWMG_ADDR_PAIR_FIRST;
            if (a >= `PWMG_ADDR_PAIR_FIRST && a <= `PWMG_ADDR_PAIR_LAST) begin
                pair_of = off[4:1];
            end else begin
                pair_of = `PWMG_PAIR_NONE;
            end
        end
    endfunction

    function is_high;
        input [7:0] a;
        reg   [7:0] off;
        begin
            off     = a - `PWMG_ADDR_PAIR_FIRST;
            is_high = off[0];
        end
    endfunction

    function period_end;
        input         run;
        input         tick;
        input [W-1:0] cnt;
        input [W-1:0] prd;
        begin
            period_end = run & tick & (cnt == prd);
        end
    endfunction

    function flag_next;
        input flag;
        input set;
        input clr_wr;
        input keep;
        begin
            if (set) begin
                flag_next = 1'h1;
            end else if (clr_wr) begin
                flag_next = flag & keep;
            end else begin
                flag_next = flag;
            end
        end
    endfunction

    function gate_out;
        input nxt;
        input sel;
        input forced;
        begin
            gate_out = nxt & (sel | forced);
        end
    endfunction

    reg  [7:0]   ie2_r;
    reg  [7:0]   ie1_r;
    reg  [7:0]   con_r;
    reg  [7:0]   oe_r;
    reg  [7:0]   ctrl_r;
    reg  [7:0]   lowbuf_r;
    reg          flag0_r;
    reg          flag1_r;
    reg  [W-1:0] pair_sh_r [0:`PWMG_PAIR_COUNT-1];
    reg  [W-1:0] ch0_prd_r;
    reg  [W-1:0] ch0_duty_r;
    reg  [W-1:0] ch0_cnt_r;
    reg  [W-1:0] sh_prd_r;
    reg  [W-1:0] sh_cnt_r;
    reg  [W-1:0] sh_duty_r [0:NS-1];
    reg  [2:0]   rc_sync_r;
    reg  [2:0]   rc2_sync_r;
    reg          raw_r;
    reg  [4:0]   dt_r;
    reg          raw_nxt;
    reg          pos_nxt;
    reg          neg_nxt;
    reg  [W-1:0] frame;
    reg  [W-1:0] effd;
    reg  [W-1:0] cnt_in2;
    reg  [4:0]   dz;
    integer      i;
    integer      j;
    integer      n;

    wire [3:0] wpair   = pair_of(reg_addr);
    wire       whigh   = is_high(reg_addr);
    wire       rc_tick  = rc_sync_r[1] & ~rc_sync_r[2];
    wire       rc2_tick = rc2_sync_r[1] & ~rc2_sync_r[2];
    // Both counters advance on the selected source.
    wire       ch0_tick = sel_tick(con_r[`PWMG_CON_CH0_CKS_HI:
                                         `PWMG_CON_CH0_CKS_LO],
                                   rc_tick, rc2_tick);
    wire       sh_tick  = sel_tick(con_r[`PWMG_CON_SH_CKS_HI:
                                         `PWMG_CON_SH_CKS_LO],
                                   rc_tick, rc2_tick);
    wire       clear0  = ctrl_r[`PWMG_CTRL_CLEAR];
    wire       mske    = ctrl_r[`PWMG_CTRL_MSKE];
    wire       half    = ctrl_r[`PWMG_CTRL_HALF];
    wire       sel_pos = oe_r[`PWMG_OE_POS_A] | oe_r[`PWMG_OE_POS_B];
    wire       sel_neg = oe_r[`PWMG_OE_NEG_A] | oe_r[`PWMG_OE_NEG_B];
    wire       run0    = (sel_pos | sel_neg) & ~clear0;
    wire       sh_run  = con_r[`PWMG_CON_SH_EN];
    wire       sh_sel  = |oe_r[`PWMG_OE_SH_HI:`PWMG_OE_SH_LO];
    wire       flg_wr  = reg_wr & (reg_addr == `PWMG_ADDR_FLG2);
    wire       end0    = period_end(run0, ch0_tick, ch0_cnt_r,
                                    ch0_prd_r);
    wire       end1    = period_end(sh_run, sh_tick, sh_cnt_r, sh_prd_r);

    // Oscillator inputs pass two flip-flops before edge detection.
    always @(posedge clk) begin
        if (!resetn) begin
            rc_sync_r  <= 3'h0;
            rc2_sync_r <= 3'h0;
        end else begin
            rc_sync_r  <= {rc_sync_r[1:0], internal_rc_clock};
            rc2_sync_r <= {rc2_sync_r[1:0], internal_rc_clock_x2};
        end
    end

    // Register writes, reads and the shared low-byte buffer.
    always @(posedge clk) begin
        if (!resetn) begin
            ie2_r     <= `PWMG_RST_BYTE;
            ie1_r     <= `PWMG_RST_BYTE;
            con_r     <= `PWMG_RST_BYTE;
            oe_r      <= `PWMG_RST_BYTE;
            ctrl_r    <= `PWMG_RST_BYTE;
            lowbuf_r  <= `PWMG_RST_BYTE;
            reg_rdata <= `PWMG_RST_BYTE;
            for (i = 0; i < `PWMG_PAIR_COUNT; i = i + 1) begin
                pair_sh_r[i] <= `PWMG_RST_WORD;
            end
        end else begin
            reg_rdata <= `PWMG_RST_BYTE;
            if (reg_wr) begin
                case (reg_addr)
                    `PWMG_ADDR_IE2:   ie2_r  <= reg_wdata & `PWMG_IE2_MASK;
                    `PWMG_ADDR_IE1:   ie1_r  <= reg_wdata;
                    `PWMG_ADDR_CON:   con_r  <= reg_wdata & `PWMG_CON_MASK;
                    `PWMG_ADDR_OE:    oe_r   <= reg_wdata;
                    `PWMG_ADDR_CTRL0: ctrl_r <= reg_wdata & `PWMG_CTRL_MASK;
                    default: begin
                        if (wpair != `PWMG_PAIR_NONE) begin
                            if (whigh) begin
                                pair_sh_r[wpair] <= {reg_wdata, lowbuf_r};
                            end else begin
                                lowbuf_r <= reg_wdata;
                            end
                        end
                    end
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `PWMG_ADDR_IE2:   reg_rdata <= ie2_r;
                    `PWMG_ADDR_FLG2:  reg_rdata <= {1'b0, flag1_r, flag0_r,
                                                    5'h00};
                    `PWMG_ADDR_IE1:   reg_rdata <= ie1_r;
                    `PWMG_ADDR_CON:   reg_rdata <= con_r;
                    `PWMG_ADDR_OE:    reg_rdata <= oe_r;
                    `PWMG_ADDR_CTRL0: reg_rdata <= ctrl_r;
                    default: begin
                        if (wpair != `PWMG_PAIR_NONE) begin
                            if (whigh) begin
                                reg_rdata <= pair_sh_r[wpair][W-1:8];
                                lowbuf_r  <= pair_sh_r[wpair][7:0];
                            end else begin
                                reg_rdata <= lowbuf_r;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Interrupt flags; a hardware set wins over a software clear.
    always @(posedge clk) begin
        if (!resetn) begin
            flag0_r <= 1'h0;
            flag1_r <= 1'h0;
        end else begin
            flag0_r <= flag_next(flag0_r, end0, flg_wr,
                                 reg_wdata[`PWMG_IE2_CH0]);
            flag1_r <= flag_next(flag1_r, end1, flg_wr,
                                 reg_wdata[`PWMG_IE2_SHARED]);
        end
    end

    // Channel zero counter and buffered period and duty.
    always @(posedge clk) begin
        if (!resetn) begin
            ch0_cnt_r  <= `PWMG_RST_WORD;
            ch0_prd_r  <= `PWMG_RST_WORD;
            ch0_duty_r <= `PWMG_RST_WORD;
        end else if (!run0) begin
            ch0_cnt_r  <= `PWMG_RST_WORD;
            ch0_prd_r  <= pair_sh_r[`PWMG_PAIR_CH0_PRD];
            ch0_duty_r <= pair_sh_r[`PWMG_PAIR_CH0_DUTY];
        end else if (end0) begin
            ch0_cnt_r  <= `PWMG_RST_WORD;
            ch0_prd_r  <= pair_sh_r[`PWMG_PAIR_CH0_PRD];
            ch0_duty_r <= pair_sh_r[`PWMG_PAIR_CH0_DUTY];
        end else if (ch0_tick) begin
            ch0_cnt_r  <= ch0_cnt_r + 1'b1;
        end
    end

    // Shared counter for channels one to six.
    always @(posedge clk) begin
        if (!resetn) begin
            sh_cnt_r <= `PWMG_RST_WORD;
            sh_prd_r <= `PWMG_RST_WORD;
            for (j = 0; j < NS; j = j + 1) begin
                sh_duty_r[j] <= `PWMG_RST_WORD;
            end
        end else if (!sh_run || end1) begin
            sh_cnt_r <= `PWMG_RST_WORD;
            sh_prd_r <= pair_sh_r[`PWMG_PAIR_SH_PRD];
            for (j = 0; j < NS; j = j + 1) begin
                sh_duty_r[j] <= pair_sh_r[`PWMG_PAIR_SH_DUTY0 + j];
            end
        end else if (sh_tick) begin
            sh_cnt_r <= sh_cnt_r + 1'b1;
        end
    end

    // Channel zero waveform, half-bridge frames and dead time.
    always @* begin
        frame   = {1'b0, ch0_prd_r[W-1:1]};
        effd    = (ch0_duty_r > frame) ? frame : ch0_duty_r;
        cnt_in2 = ch0_cnt_r - frame;
        dz      = {1'b0, ctrl_r[`PWMG_CTRL_DZ_HI:`PWMG_CTRL_DZ_LO]};
        raw_nxt = run0 & (ch0_cnt_r < ch0_duty_r);
        pos_nxt = 1'b0;
        neg_nxt = 1'b0;
        if (mske && clear0) begin
            pos_nxt = con_r[`PWMG_CON_PMSK];
            neg_nxt = con_r[`PWMG_CON_NMSK];
        end else if (!run0) begin
            pos_nxt = 1'b0;
            neg_nxt = 1'b0;
        end else if (half) begin
            pos_nxt = (ch0_cnt_r < frame) && (ch0_cnt_r < effd);
            neg_nxt = (ch0_cnt_r >= frame) && (cnt_in2 < effd);
        end else if (dz == `PWMG_DT_ZERO) begin
            pos_nxt = raw_r;
            neg_nxt = raw_r;
        end else begin
            pos_nxt = raw_r & (dt_r >= dz);
            neg_nxt = ~raw_r & (dt_r >= dz);
        end
    end

    // Raw channel zero level and dead-time count since its last change.
    always @(posedge clk) begin
        if (!resetn) begin
            raw_r <= 1'h0;
            dt_r  <= `PWMG_DT_ZERO;
        end else begin
            raw_r <= raw_nxt;
            if (raw_nxt != raw_r) begin
                dt_r <= `PWMG_DT_ZERO;
            end else if (ch0_tick && dt_r != `PWMG_DT_MAX) begin
                dt_r <= dt_r + 1'h1;
            end
        end
    end

    // Channel zero output stage.
    always @(posedge clk) begin
        if (!resetn) begin
            ch0_pos_output <= 1'h0;
            ch0_neg_output <= 1'h0;
        end else begin
            ch0_pos_output <= gate_out(pos_nxt, sel_pos, mske & clear0);
            ch0_neg_output <= gate_out(neg_nxt, sel_neg, mske & clear0);
        end
    end

    // Shared channel outputs.
    always @(posedge clk) begin
        if (!resetn) begin
            shared_output <= {NS{1'h0}};
        end else begin
            for (n = 0; n < NS; n = n + 1) begin
                shared_output[n] <= sh_run & sh_sel &
                                    (sh_cnt_r < sh_duty_r[n]);
            end
        end
    end

    // Interrupt requests follow the flags, gated by their enables.
    always @(posedge clk) begin
        if (!resetn) begin
            ch0_irq    <= 1'h0;
            shared_irq <= 1'h0;
        end else begin
            ch0_irq    <= flag0_r & ie2_r[`PWMG_IE2_CH0] &
                          ie1_r[`PWMG_IE1_ALL];
            shared_irq <= flag1_r & ie2_r[`PWMG_IE2_SHARED] &
                          ie1_r[`PWMG_IE1_ALL];
        end
    end

endmodule
`default_nettype wire

// ### pwmg_checker.sv
// Port assertions of the seven-channel PWM generator.
`timescale 1ns/10ps
`default_nettype none
module pwmg_checker #(
    parameter W  = 16,
    parameter NS = 6
) (
    // Clock, reset and register port.
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic [7:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [7:0]    reg_rdata,
    // Oscillators and outputs.
    input wire logic          internal_rc_clock,
    input wire logic          internal_rc_clock_x2,
    input wire logic          ch0_pos_output,
    input wire logic          ch0_neg_output,
    input wire logic [NS-1:0] shared_output,
    input wire logic          ch0_irq,
    input wire logic          shared_irq
);
    logic [7:0] con_r, ctrl_r, ie2_r, ie1_r;
    logic       msk, sep;
    assign msk = ctrl_r[0] & ctrl_r[1];
    assign sep = (ctrl_r[7:4] != 4'h0 || ctrl_r[2]) && !msk;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            con_r  <= 8'h00;
            ctrl_r <= 8'h00;
            ie2_r  <= 8'h00;
            ie1_r  <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                8'hA1: con_r <= reg_wdata;
                8'hB0: ctrl_r <= reg_wdata;
                8'h84: ie2_r <= reg_wdata;
                8'hA9: ie1_r <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence flag0_clr;
        reg_wr && reg_addr == 8'h85 && !reg_wdata[5] && ctrl_r[0];
    endsequence
    sequence flag_read;
        reg_rd && reg_addr == 8'h85;
    endsequence
    flag0_clear_a: assert property (
        flag0_clr ##[1:2] flag_read |=> !reg_rdata[5])
        else $error("ch0 flag kept after clear");
    ie2_read_a: assert property (
        reg_rd && reg_addr == 8'h84 |=> reg_rdata == (ie2_r & 8'h60))
        else $error("enable register read wrong");
    con_read_a: assert property (
        reg_rd && reg_addr == 8'hA1 |=> reg_rdata == (con_r & 8'hEF))
        else $error("control register read wrong");
    irq_gate_a: assert property (
        ch0_irq |-> $past(ie2_r[5] && ie1_r[7]))
        else $error("ch0 irq without enable");
    ch0_irq_off_a: assert property (
        reg_wr && reg_addr == 8'h84 && !reg_wdata[5] |-> ##2 !ch0_irq)
        else $error("ch0 irq stays after disable");
    sh_irq_off_a: assert property (
        reg_wr && reg_addr == 8'h84 && !reg_wdata[6] |-> ##2 !shared_irq)
        else $error("shared irq stays after disable");
    no_overlap_a: assert property (
        sep && $past(sep) && $past(sep, 2) && $past(sep, 3)
        |-> !(ch0_pos_output && ch0_neg_output))
        else $error("outputs overlap");
    mask_out_a: assert property (
        msk && $stable(ctrl_r) && $stable(con_r)
        |-> ch0_pos_output == con_r[0] && ch0_neg_output == con_r[1])
        else $error("mask levels not driven");
    hold_zero_a: assert property (
        ctrl_r[0] && !ctrl_r[1] && $stable(ctrl_r)
        && ctrl_r == $past(ctrl_r, 2) && ctrl_r == $past(ctrl_r, 3)
        |-> !ch0_pos_output && !ch0_neg_output)
        else $error("held channel drives output");
endmodule
bind pwmg_top pwmg_checker #(.W(W), .NS(NS)) i_pwmg_checker (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .internal_rc_clock(internal_rc_clock),
    .internal_rc_clock_x2(internal_rc_clock_x2),
    .ch0_pos_output(ch0_pos_output), .ch0_neg_output(ch0_neg_output),
    .shared_output(shared_output), .ch0_irq(ch0_irq),
    .shared_irq(shared_irq));
`default_nettype wire

// ### test_pwmg_top.sv
// Self-checking testbench of the seven-channel PWM generator.
`timescale 1ns/10ps
`default_nettype none
module test_pwmg_top;
    logic        clk, resetn, reg_wr, reg_rd, rc, rc2, pos, neg, irq0, irq1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, div;
    logic [5:0]  sh;
    logic [15:0] pv [9];
    logic [7:0]  ra [6] = '{8'h84, 8'h85, 8'hA9, 8'hA1, 8'hA6, 8'hB0};
    integer      miscompares, total_checks, seed, i, k, d, d2, t, np, nn, ns;
    pwmg_top i_pwmg_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .internal_rc_clock(rc),
        .internal_rc_clock_x2(rc2), .ch0_pos_output(pos),
        .ch0_neg_output(neg), .shared_output(sh), .ch0_irq(irq0),
        .shared_irq(irq1));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        div <= div + 8'h01;
        rc  <= div[2];
        rc2 <= div[1];
    end
    function integer mn(input integer a, input integer b);
        mn = a < b ? a : b;
    endfunction
    task chk(input logic [15:0] s, input logic [15:0] e);
        total_checks = total_checks + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, reg_rdata}, {8'h00, e});
        @(posedge clk);
    endtask
    task pair(input integer p, input logic [15:0] v);
        wr(8'hB1 + 8'(2 * p), v[7:0]);
        wr(8'hB2 + 8'(2 * p), v[15:8]);
    endtask
    task cfg(input logic [7:0] c0, input logic [7:0] cn, input logic [7:0] oe,
             input logic [15:0] du, input logic [15:0] du2);
        integer q;
        wr(8'hB0, 8'h01);
        pair(0, 16'h0009);
        pair(1, du);
        pair(2, 16'h0009);
        for (q = 3; q < 9; q++)
            pair(q, du2);
        wr(8'hA1, cn);
        wr(8'hA6, oe);
        wr(8'hB0, c0);
        repeat (200) @(posedge clk);
    endtask
    task meas(input integer n);
        np = 0;
        nn = 0;
        ns = 0;
        repeat (n) begin
            @(negedge clk);
            np = np + pos;
            nn = nn + neg;
            ns = ns + (sh == 6'h3F);
        end
        @(posedge clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        miscompares = miscompares + 1;
        finish_test;
    end
    initial begin
        miscompares  = 0;
        total_checks = 0;
        seed         = 32'hF3001639;
        resetn       = 1'b0;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        div          = 8'h00;
        rc           = 1'b0;
        rc2          = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (ra[k]) rd(ra[k], 8'h00);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(8'hA1, d[7:0]);
            rd(8'hA1, d[7:0] & 8'hEF);
            wr(8'hB0, d[15:8]);
            rd(8'hB0, d[15:8] & 8'hF7);
            wr(8'h84, d[23:16]);
            rd(8'h84, d[23:16] & 8'h60);
            wr(8'h7F, d[31:24]);
            rd(8'h7F, 8'h00);
        end
        wr(8'hB0, 8'h01);
        for (k = 0; k < 9; k++) begin
            pv[k] = $random(seed);
            pair(k, pv[k]);
        end
        for (i = 0; i < 9; i++) begin
            rd(8'hB2 + 8'(2 * i), pv[i][15:8]);
            rd(8'hB1 + 8'(2 * i), pv[i][7:0]);
        end
        for (i = 0; i < 4; i++) begin
            t  = i < 2 ? 1 : (i == 2 ? 8 : 4);
            d  = 1 + ($random(seed) & 7);
            d2 = 1 + ($random(seed) & 7);
            cfg(8'h00, {i[1:0], 2'b10, i[1:0], 2'b00}, 8'h13, d, d2);
            meas(40 * t);
            chk(np, 4 * t * d);
            chk(nn, 4 * t * d);
            chk(ns, 4 * t * d2);
        end
        d = 4 + ($random(seed) & 3);
        cfg(8'h30, 8'h20, 8'h13, d, d);
        meas(40);
        chk(np, 4 * (d - 3));
        chk(nn, 4 * (7 - d));
        d = 1 + ($random(seed) & 7);
        cfg(8'h04, 8'h20, 8'h13, d, d);
        meas(40);
        chk(np, 4 * mn(d, 4));
        chk(nn, 4 * mn(d, 4));
        wr(8'hB0, 8'h01);
        wr(8'hA1, 8'h00);
        rd(8'h85, 8'h60);
        wr(8'h84, 8'h60);
        wr(8'hA9, 8'h80);
        @(negedge clk);
        chk({irq0, irq1}, 2'b11);
        wr(8'h85, 8'hFF);
        rd(8'h85, 8'h60);
        wr(8'h85, 8'hBF);
        rd(8'h85, 8'h20);
        chk({irq0, irq1}, 2'b10);
        wr(8'h85, 8'hDF);
        rd(8'h85, 8'h00);
        for (k = 1; k < 3; k++) begin
            cfg(8'h03, k[7:0], 8'h00, 5, 5);
            meas(40);
            chk(np, 40 * k[0]);
            chk(nn, 40 * k[1]);
        end
        cfg(8'h01, 8'h03, 8'h13, 5, 5);
        meas(40);
        chk(np + nn, 0);
        cfg(8'h00, 8'h00, 8'h00, 5, 5);
        meas(40);
        chk(np + nn, 0);
        finish_test;
    end
endmodule
`default_nettype wire
